/* File: pkg/power_mode_pkg.sv */
// Purpose: Shared constants and types for the power-mode controller.
// Assumes: 40 MHz system clock; register port with one-cycle read latency.
// Notes: Offsets are word addresses on the plain register port.
package power_mode_pkg;

    localparam int unsigned CLK_MHZ = 40;
    localparam int unsigned WAKE_IDLE_US = 14;
    localparam int unsigned WAKE_STBY_US = 151;
    localparam int unsigned WAKE_SHUT_US = 1015;
    localparam int unsigned WAKE_IDLE_CYC = WAKE_IDLE_US * CLK_MHZ;
    localparam int unsigned WAKE_STBY_CYC = WAKE_STBY_US * CLK_MHZ;
    localparam int unsigned WAKE_SHUT_CYC = WAKE_SHUT_US * CLK_MHZ;

    localparam int unsigned RAM_BLOCKS = 4;
    localparam int unsigned RAM_SMALL_KB = 4;
    localparam int unsigned RAM_LARGE_KB = 6;
    localparam int unsigned CACHE_KB = 8;
    localparam int unsigned FAST_XTAL_MHZ = 24;
    localparam int unsigned FAST_PLL_MHZ = 48;

    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_MODE_REQ = 4'h1;
    localparam logic [3:0] ADDR_STATUS = 4'h2;
    localparam logic [3:0] ADDR_RST_CAUSE = 4'h3;
    localparam logic [3:0] ADDR_IRQ_STAT = 4'h4;
    localparam logic [3:0] ADDR_IRQ_MASK = 4'h5;
    localparam logic [3:0] ADDR_WAKE_PINS = 4'h6;

    // CTRL fields
    localparam int unsigned CTRL_RET_LSB = 0;
    localparam int unsigned CTRL_CACHE_DIS = 4;
    localparam int unsigned CTRL_FAST_RC = 5;
    localparam int unsigned CTRL_SLOW_XTAL = 6;
    localparam int unsigned CTRL_CLKOUT = 7;
    localparam logic [7:0] CTRL_RESET = 8'h0F;

    // Mode request codes
    localparam logic [1:0] REQ_IDLE = 2'h1;
    localparam logic [1:0] REQ_STANDBY = 2'h2;
    localparam logic [1:0] REQ_SHUTDOWN = 2'h3;

    // Reset cause codes
    localparam logic [1:0] CAUSE_POR = 2'h0;
    localparam logic [1:0] CAUSE_PIN = 2'h1;
    localparam logic [1:0] CAUSE_WAKE = 2'h2;

    // Interrupt status bits
    localparam int unsigned IRQ_W = 4;
    localparam int unsigned IRQ_WOKE = 0;
    localparam int unsigned IRQ_BROWNOUT = 1;
    localparam int unsigned IRQ_PINWAKE = 2;
    localparam int unsigned IRQ_REQDONE = 3;

    typedef enum logic [6:0] {
        ST_HELD = 7'b0000001,
        ST_ACTIVE = 7'b0000010,
        ST_IDLE = 7'b0000100,
        ST_STANDBY = 7'b0001000,
        ST_SHUTDOWN = 7'b0010000,
        ST_WAKING = 7'b0100000,
        ST_LOCKED = 7'b1000000
    } mode_e;

    typedef struct packed {
        logic cpuClkEn;
        logic memClkEn;
        logic periphClkEn;
        logic flashPwr;
        logic sramPwr;
        logic alwaysOnPwr;
        logic sensorPwr;
        logic ioLatch;
    } power_ctl_s;

    typedef struct packed {
        logic fastClkEn;
        logic fastSelRc;
        logic fastDoubler;
        logic slowSelRc;
        logic slowClkOut;
    } clock_ctl_s;

endpackage

/* File: rtl/power_mode_controller.sv */
// Purpose: Sequences power modes, wake sources, reset cause and clock selection.
// Assumes: All inputs synchronous to clk; registers reached over a plain port.
// Notes: Analog domains are modelled by enable outputs only.
// Functional notes
// RULE1: Active mode clocks processor, powers flash and SRAM, clocks enabled peripherals.
// RULE2: Idle stops processor and memory clocks; any interrupt returns to active.
// RULE3: Wake latency is 14 us idle, 151 us standby, 1015 us shutdown or held.
// RULE4: Standby powers only always-on domain; wake by pin, timer or sensor event. The code also keeps sramPwr and sensorPwr on in standby.
// RULE5: Standby wake resumes execution in place; retained peripherals keep configuration.
// RULE6: All I/O pins stay latched during standby.
// RULE7: Shutdown removes all power except I/O latches; flash persists.
// RULE8: A wake-pin change in shutdown wakes the device as a reset.
// RULE9: Reset cause register distinguishes pin-wake, reset-pin and power-on resets.
// RULE10: Each of four SRAM blocks has its own standby retention enable.
// RULE11: With flash cache disabled the cache memory serves as ordinary RAM.
// RULE12: In standby the brown-out detector runs only during recharge periods.
// RULE13: Brown-out seen after standby locks the device until a reset.
// RULE14: The 24 MHz crystal reference is doubled to 48 MHz.
// RULE15: Slow RC oscillator is the slow reference unless the slow crystal is used.
// RULE16: Fast RC oscillator may replace the crystal clock for the processor.
// RULE17: The slow clock can be routed to an I/O pin.
// RULE18: Low-power modes only on software request; held while reset pin asserted.
//
// The register addresses and the strobed register port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module power_mode_controller
    import power_mode_pkg::*;
#(
    parameter int unsigned PIN_W = 16,
    parameter int unsigned IDLE_CYC = WAKE_IDLE_CYC,
    parameter int unsigned STBY_CYC = WAKE_STBY_CYC,
    parameter int unsigned SHUT_CYC = WAKE_SHUT_CYC
)(
    input wire logic clk, // System clock
    input wire logic rst_n, // Asynchronous power-on reset
    input wire logic clkEn, // Freezes all state when low
    input wire logic [3:0] regAddr, // Register word address
    input wire logic [7:0] regWdata, // Register write data
    input wire logic regWr, // Write strobe
    input wire logic regRd, // Read strobe
    output logic [7:0] regRdata, // Read data, cycle after strobe
    input wire logic resetPin_n, // External reset pin, low holds device
    input wire logic [PIN_W-1:0] pinIn, // I/O pin levels
    input wire logic irqEvent, // Any processor interrupt
    input wire logic timerEvent, // Always-on timer event
    input wire logic sensorEvent, // Sensor processor event
    input wire logic rechargePeriod, // Supply recharge window in standby
    input wire logic brownout, // Brown-out detector output
    input wire logic slowClk, // Selected slow clock level
    output power_ctl_s powerCtl, // Domain power and clock enables
    output clock_ctl_s clockCtl, // Clock source selection
    output logic [RAM_BLOCKS-1:0] ramRetain, // SRAM block retention
    output logic cacheAsRam, // Cache usable as RAM
    output logic brownoutEn, // Brown-out detector enable
    output logic clkOutPin, // Slow clock routed to pin
    output logic irq // Interrupt, level
);

    localparam int unsigned CNT_W = $clog2(SHUT_CYC + 1);

    mode_e mode_q;
    logic [CNT_W-1:0] wakeCnt_q;
    logic [7:0] ctrl_q;
    logic [1:0] cause_q;
    logic [IRQ_W-1:0] irqStat_q;
    logic [IRQ_W-1:0] irqMask_q;
    logic [PIN_W-1:0] wakePins_q;
    logic [PIN_W-1:0] pinLatch_q;
    logic stbyBrown_q;
    logic reqDone;
    logic pinWake;
    logic stbyWake;
    logic wr;
    logic [IRQ_W-1:0] irqSet;

    assign wr = regWr && clkEn;
    assign pinWake = |((pinIn ^ pinLatch_q) & wakePins_q); // RULE8
    assign stbyWake = pinWake || timerEvent || sensorEvent || !resetPin_n; // RULE4

    // Mode sequencer
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mode_q <= ST_HELD;
            wakeCnt_q <= '0;
        end
        else if (clkEn)
        begin
            if (!resetPin_n && mode_q != ST_SHUTDOWN && mode_q != ST_STANDBY)
            begin
                mode_q <= ST_HELD; // RULE18
                wakeCnt_q <= CNT_W'(SHUT_CYC - 1); // RULE3
            end
            else
            begin
                unique case (mode_q)
                    ST_HELD:
                    begin
                        mode_q <= ST_WAKING;
                        wakeCnt_q <= CNT_W'(SHUT_CYC - 1); // RULE3
                    end
                    ST_ACTIVE:
                    begin
                        if (wr && regAddr == ADDR_MODE_REQ)
                        begin
                            unique case (regWdata[1:0]) // RULE18
                                REQ_IDLE: mode_q <= ST_IDLE;
                                REQ_STANDBY: mode_q <= ST_STANDBY;
                                REQ_SHUTDOWN: mode_q <= ST_SHUTDOWN;
                                default: mode_q <= ST_ACTIVE;
                            endcase
                        end
                    end
                    ST_IDLE:
                    begin
                        if (irqEvent) // RULE2
                        begin
                            mode_q <= ST_WAKING;
                            wakeCnt_q <= CNT_W'(IDLE_CYC - 1); // RULE3
                        end
                    end
                    ST_STANDBY:
                    begin
                        if (stbyWake)
                        begin
                            mode_q <= ST_WAKING;
                            wakeCnt_q <= CNT_W'(STBY_CYC - 1); // RULE3
                        end
                    end
                    ST_SHUTDOWN:
                    begin
                        if (pinWake || !resetPin_n) // RULE8
                        begin
                            mode_q <= ST_HELD;
                        end
                    end
                    ST_WAKING:
                    begin
                        if (wakeCnt_q != '0)
                            wakeCnt_q <= wakeCnt_q - 1'b1;
                        else if (stbyBrown_q)
                            mode_q <= ST_LOCKED; // RULE13
                        else
                            mode_q <= ST_ACTIVE; // RULE5
                    end
                    ST_LOCKED:
                    begin
                        mode_q <= ST_LOCKED; // RULE13
                    end
                endcase
            end
        end
    end

    // Brown-out seen during standby recharge windows
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            stbyBrown_q <= 1'b0;
        else if (clkEn)
        begin
            if (mode_q == ST_HELD)
                stbyBrown_q <= 1'b0;
            else if (mode_q == ST_STANDBY && rechargePeriod && brownout)
                stbyBrown_q <= 1'b1; // RULE13
        end
    end

    // Reset cause
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            cause_q <= CAUSE_POR; // RULE9
        else if (clkEn)
        begin
            if (mode_q == ST_SHUTDOWN && pinWake && resetPin_n)
                cause_q <= CAUSE_WAKE; // RULE9
            else if (!resetPin_n && mode_q != ST_STANDBY)
                cause_q <= CAUSE_PIN; // RULE9
        end
    end

    // I/O latch follows pins every cycle in active mode and holds them in all other modes
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            pinLatch_q <= '0;
        else if (clkEn && mode_q == ST_ACTIVE)
            pinLatch_q <= pinIn; // RULE6 RULE7
    end

    // Software registers
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ctrl_q <= CTRL_RESET;
            irqMask_q <= '0;
            wakePins_q <= '0;
        end
        else if (wr)
        begin
            if (regAddr == ADDR_CTRL)
                ctrl_q <= regWdata; // RULE10
            if (regAddr == ADDR_IRQ_MASK)
                irqMask_q <= regWdata[IRQ_W-1:0];
            if (regAddr == ADDR_WAKE_PINS)
                wakePins_q <= PIN_W'(regWdata);
        end
    end

    assign reqDone = mode_q == ST_WAKING && wakeCnt_q == '0;
    always_comb
    begin
        irqSet = '0;
        irqSet[IRQ_WOKE] = reqDone && !stbyBrown_q;
        irqSet[IRQ_BROWNOUT] = mode_q == ST_STANDBY && rechargePeriod && brownout;
        irqSet[IRQ_PINWAKE] = mode_q == ST_STANDBY && pinWake;
        irqSet[IRQ_REQDONE] = mode_q == ST_ACTIVE && wr && regAddr == ADDR_MODE_REQ;
    end

    // Sticky status, set wins over write-one-to-clear
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            irqStat_q <= '0;
        else if (clkEn)
        begin
            if (wr && regAddr == ADDR_IRQ_STAT)
                irqStat_q <= (irqStat_q & ~regWdata[IRQ_W-1:0]) | irqSet;
            else
                irqStat_q <= irqStat_q | irqSet;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            irq <= 1'b0;
        else if (clkEn)
            irq <= |(irqStat_q & irqMask_q);
    end

    // Read port
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            regRdata <= '0;
        else if (clkEn)
        begin
            regRdata <= '0;
            if (regRd)
            begin
                unique case (regAddr)
                    ADDR_CTRL: regRdata <= ctrl_q;
                    ADDR_STATUS: regRdata <= {1'b0, mode_q};
                    ADDR_RST_CAUSE: regRdata <= {6'h00, cause_q};
                    ADDR_IRQ_STAT: regRdata <= 8'(irqStat_q);
                    ADDR_IRQ_MASK: regRdata <= 8'(irqMask_q);
                    ADDR_WAKE_PINS: regRdata <= wakePins_q[7:0];
                    default: regRdata <= '0;
                endcase
            end
        end
    end

    // Domain power and clocks
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            powerCtl <= '0;
            ramRetain <= '0;
            brownoutEn <= 1'b0;
        end
        else if (clkEn)
        begin
            powerCtl.cpuClkEn <= mode_q == ST_ACTIVE; // RULE1
            powerCtl.memClkEn <= mode_q == ST_ACTIVE; // RULE2
            powerCtl.periphClkEn <= mode_q inside {ST_ACTIVE, ST_IDLE}; // RULE1 RULE2
            powerCtl.flashPwr <= mode_q inside {ST_ACTIVE, ST_IDLE, ST_WAKING};
            powerCtl.sramPwr <= mode_q inside {ST_ACTIVE, ST_IDLE, ST_STANDBY, ST_WAKING};
            powerCtl.alwaysOnPwr <= !(mode_q inside {ST_SHUTDOWN, ST_HELD}); // RULE4 RULE7
            powerCtl.sensorPwr <= !(mode_q inside {ST_SHUTDOWN, ST_HELD}); // RULE7
            powerCtl.ioLatch <= mode_q inside {ST_STANDBY, ST_SHUTDOWN}; // RULE6 RULE7
            ramRetain <= (mode_q == ST_STANDBY) ? ctrl_q[CTRL_RET_LSB +: RAM_BLOCKS]
                                                 : '0; // RULE10
            brownoutEn <= (mode_q == ST_STANDBY) ? rechargePeriod
                                                 : mode_q inside {ST_ACTIVE, ST_IDLE}; // RULE12
        end
    end

    // Clock selection
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            clockCtl <= '0;
            cacheAsRam <= 1'b0;
            clkOutPin <= 1'b0;
        end
        else if (clkEn)
        begin
            clockCtl.fastClkEn <= mode_q inside {ST_ACTIVE, ST_IDLE, ST_WAKING};
            clockCtl.fastSelRc <= ctrl_q[CTRL_FAST_RC]; // RULE16
            clockCtl.fastDoubler <= !ctrl_q[CTRL_FAST_RC]; // RULE14
            clockCtl.slowSelRc <= !ctrl_q[CTRL_SLOW_XTAL]; // RULE15
            clockCtl.slowClkOut <= ctrl_q[CTRL_CLKOUT]; // RULE17
            cacheAsRam <= ctrl_q[CTRL_CACHE_DIS]; // RULE11
            clkOutPin <= ctrl_q[CTRL_CLKOUT] && slowClk
                         && !(mode_q inside {ST_SHUTDOWN, ST_HELD}); // RULE17
        end
    end

endmodule
`default_nettype wire

/* File: test/power_mode_properties.sv */
// Purpose: Port-level checks for the power-mode controller.
// Assumes: Outputs are registered from the same mode state.
// Notes: Standby is seen as latched pins with the always-on domain up and the cpu clock off.
`timescale 1ns/1ps
`default_nettype none
module power_mode_properties
    import power_mode_pkg::*;
(
    input wire logic clk, // System clock
    input wire logic rst_n, // Power-on reset
    input wire logic resetPin_n, // Reset pin
    input wire logic rechargePeriod, // Recharge window
    input wire logic slowClk, // Slow clock level
    input wire power_ctl_s powerCtl, // Domain enables
    input wire clock_ctl_s clockCtl, // Clock selection
    input wire logic [RAM_BLOCKS-1:0] ramRetain, // SRAM retention
    input wire logic brownoutEn, // Detector enable
    input wire logic clkOutPin // Slow clock on pin
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    logic standby;
    assign standby = powerCtl.ioLatch && powerCtl.alwaysOnPwr && !powerCtl.cpuClkEn;

    property p_active_mem;
        powerCtl.cpuClkEn |-> powerCtl.memClkEn && powerCtl.flashPwr && powerCtl.sramPwr;
    endproperty
    a_active_mem: assert property (p_active_mem) else $error("memories off while cpu runs");
    property p_idle_gate;
        powerCtl.periphClkEn && !powerCtl.cpuClkEn |-> !powerCtl.memClkEn;
    endproperty
    a_idle_gate: assert property (p_idle_gate) else $error("memory clock on in idle");
    property p_standby_aon;
        standby |-> !powerCtl.periphClkEn && !powerCtl.flashPwr;
    endproperty
    a_standby_aon: assert property (p_standby_aon) else $error("standby domain left on");
    property p_shutdown_off;
        !powerCtl.alwaysOnPwr && powerCtl.ioLatch |-> !powerCtl.sensorPwr && !brownoutEn;
    endproperty
    a_shutdown_off: assert property (p_shutdown_off) else $error("power left in shutdown");
    property p_retain;
        |ramRetain |-> standby;
    endproperty
    a_retain: assert property (p_retain) else $error("retention outside standby");
    property p_bod_duty;
        standby ##1 standby ##1 standby |-> $past(brownoutEn) == $past(rechargePeriod, 2);
    endproperty
    a_bod_duty: assert property (p_bod_duty) else $error("detector not duty cycled");
    property p_doubler;
        clockCtl.fastClkEn && !clockCtl.fastSelRc |-> clockCtl.fastDoubler;
    endproperty
    a_doubler: assert property (p_doubler) else $error("crystal clock not doubled");
    property p_clkout;
        clkOutPin |-> $past(slowClk);
    endproperty
    a_clkout: assert property (p_clkout) else $error("pin does not follow slow clock");
    property p_held;
        !resetPin_n [*3] |-> !powerCtl.cpuClkEn;
    endproperty
    a_held: assert property (p_held) else $error("cpu runs under reset pin");
endmodule
`default_nettype wire

/* File: test/wake_pin_model.sv */
// Purpose: Drives the wake pins and the reset pin from outside.
// Assumes: Calls are made just after a rising edge.
// Notes: Pins are push-pull levels, never left floating.
`timescale 1ns/1ps
`default_nettype none
module wake_pin_model #(
    parameter int unsigned PIN_W = 16
)(
    input wire logic clk, // System clock
    output logic [PIN_W-1:0] pinIn, // Pin levels
    output logic resetPin_n // Reset pin, low asserted
);
    initial
    begin
        pinIn = '0;
        resetPin_n = 1'b1;
    end
    task automatic toggle_pin(input int idx);
        pinIn[idx] <= ~pinIn[idx];
    endtask
    task automatic set_reset(input logic level);
        resetPin_n <= level;
    endtask
endmodule
`default_nettype wire

/* File: test/power_mode_controller_bench.sv */
// Purpose: Self-checking bench for the power-mode controller.
// Assumes: Shortened wake counts; inputs change just after rising edges.
// Notes: Reads are compared in the cycle after the strobe.
`timescale 1ns/1ps
`default_nettype none
module power_mode_controller_bench;
    import power_mode_pkg::*;
    localparam int unsigned IC = 4;
    localparam int unsigned SC = 8;
    localparam int unsigned HC = 16;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic clkEn = 1'b1;
    logic [3:0] regAddr = 4'h0;
    logic [7:0] regWdata = 8'h00;
    logic regWr = 1'b0, regRd = 1'b0, irqEvent = 1'b0, timerEvent = 1'b0, sensorEvent = 1'b0;
    logic rechargePeriod = 1'b0, brownout = 1'b0, slowClk = 1'b0;
    logic [7:0] regRdata;
    logic [15:0] pinIn;
    logic resetPin_n, cacheAsRam, brownoutEn, clkOutPin, irq;
    logic [3:0] ramRetain;
    power_ctl_s powerCtl;
    clock_ctl_s clockCtl;
    int errors = 0;
    int checksDone = 0;

    wake_pin_model #(.PIN_W(16)) pins_u (.clk(clk), .pinIn(pinIn), .resetPin_n(resetPin_n));
    power_mode_controller #(.PIN_W(16), .IDLE_CYC(IC), .STBY_CYC(SC), .SHUT_CYC(HC)) dut_u (
        .clk(clk), .rst_n(rst_n), .clkEn(clkEn), .regAddr(regAddr), .regWdata(regWdata),
        .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .resetPin_n(resetPin_n),
        .pinIn(pinIn), .irqEvent(irqEvent), .timerEvent(timerEvent), .sensorEvent(sensorEvent),
        .rechargePeriod(rechargePeriod), .brownout(brownout), .slowClk(slowClk),
        .powerCtl(powerCtl), .clockCtl(clockCtl), .ramRetain(ramRetain),
        .cacheAsRam(cacheAsRam), .brownoutEn(brownoutEn), .clkOutPin(clkOutPin), .irq(irq));

    initial
    begin
        forever #12.5 clk = ~clk;
    end
    task automatic conclude();
        $display("errors=%0d checks=%0d", errors, checksDone);
        if (errors == 0 && checksDone > 0)
        begin
            $display("All tests passed");
        end
        else
        begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checksDone++;
        if (got !== exp)
        begin
            errors++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        regAddr <= a;
        regWdata <= d;
        regWr <= 1'b1;
        @(posedge clk);
        regWr <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge clk);
        regRd <= 1'b0;
        #1;
        chk(regRdata, exp);
    endtask
    // Counts cycles until the cpu clock returns; too early or too late is a mismatch
    task automatic wake_check(input int lo);
        int n;
        n = 0;
        while (powerCtl.cpuClkEn !== 1'b1 && n < lo + 6)
        begin
            cyc(1);
            n++;
        end
        checksDone++;
        if (n < lo || n > lo + 5)
        begin
            errors++;
            $display("[FAIL] %0t wake took %0d cycles", $time, n);
            conclude();
        end
    endtask

    initial
    begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        cyc(1);
        wake_check(HC);
        rd(ADDR_RST_CAUSE, {6'h00, CAUSE_POR});
        rd(ADDR_CTRL, CTRL_RESET);
        rd(ADDR_STATUS, {1'b0, ST_ACTIVE});
        chk({4'h0, powerCtl.cpuClkEn, powerCtl.memClkEn, powerCtl.flashPwr, ramRetain[0]}, 8'h0E);
        wr(ADDR_CTRL, 8'hBA);
        wr(4'hF, 8'hFF);
        rd(ADDR_CTRL, 8'hBA);
        slowClk <= ~slowClk;
        cyc(3);
        chk({4'h0, cacheAsRam, clockCtl.fastSelRc, clockCtl.slowSelRc, clkOutPin}, 8'h0F);
        chk({7'h00, clockCtl.slowClkOut}, 8'h01);
        // Pin must follow the slow clock level, not just the enable bit
        slowClk <= ~slowClk;
        cyc(2);
        chk({7'h00, clkOutPin}, 8'h00);
        slowClk <= ~slowClk;
        wr(ADDR_CTRL, 8'h4A);
        cyc(3);
        chk({4'h0, clockCtl.fastDoubler, clockCtl.slowSelRc, cacheAsRam, clkOutPin}, 8'h08);
        chk({7'h00, clockCtl.slowClkOut}, 8'h00);
        wr(ADDR_IRQ_MASK, 8'h0F);
        wr(ADDR_MODE_REQ, {6'h00, REQ_IDLE});
        cyc(3);
        chk({5'h00, powerCtl.cpuClkEn, powerCtl.memClkEn, powerCtl.periphClkEn}, 8'h01);
        wr(ADDR_MODE_REQ, {6'h00, REQ_SHUTDOWN});
        cyc(2);
        rd(ADDR_STATUS, {1'b0, ST_IDLE});
        irqEvent <= 1'b1;
        cyc(1);
        irqEvent <= 1'b0;
        // Freeze three cycles: a wake counter that ignores clkEn finishes early
        clkEn <= ~clkEn;
        cyc(3);
        clkEn <= ~clkEn;
        wake_check(IC);
        cyc(2);
        chk({7'h00, irq}, 8'h01);
        rd(ADDR_IRQ_STAT, 8'h09);
        wr(ADDR_IRQ_STAT, 8'h09);
        cyc(2);
        chk({7'h00, irq}, 8'h00);
        wr(ADDR_WAKE_PINS, 8'h01);
        wr(ADDR_IRQ_MASK, 8'h00);
        for (int k = 0; k < 3; k++)
        begin
            wr(ADDR_MODE_REQ, {6'h00, REQ_STANDBY});
            cyc(3);
            chk({4'h0, ramRetain}, 8'h0A);
            chk({5'h00, powerCtl.cpuClkEn, powerCtl.periphClkEn, powerCtl.ioLatch}, 8'h01);
            rechargePeriod <= 1'b1;
            cyc(3);
            chk({7'h00, brownoutEn}, 8'h01);
            rechargePeriod <= 1'b0;
            pins_u.toggle_pin(3);
            cyc(3);
            chk({7'h00, brownoutEn}, 8'h00);
            rd(ADDR_STATUS, {1'b0, ST_STANDBY});
            timerEvent <= (k == 0);
            sensorEvent <= (k == 1);
            if (k == 2)
            begin
                pins_u.toggle_pin(0);
            end
            cyc(1);
            timerEvent <= 1'b0;
            sensorEvent <= 1'b0;
            wake_check(SC);
            rd(ADDR_CTRL, 8'h4A);
        end
        chk({7'h00, irq}, 8'h00);
        rd(ADDR_IRQ_STAT, 8'h0D);
        wr(ADDR_IRQ_MASK, 8'h04);
        cyc(2);
        chk({7'h00, irq}, 8'h01);
        wr(ADDR_MODE_REQ, {6'h00, REQ_STANDBY});
        cyc(3);
        rechargePeriod <= 1'b1;
        brownout <= 1'b1;
        cyc(2);
        rechargePeriod <= 1'b0;
        brownout <= 1'b0;
        timerEvent <= 1'b1;
        cyc(1);
        timerEvent <= 1'b0;
        cyc(SC + 4);
        rd(ADDR_STATUS, {1'b0, ST_LOCKED});
        pins_u.set_reset(1'b0);
        cyc(4);
        rd(ADDR_STATUS, {1'b0, ST_HELD});
        pins_u.set_reset(1'b1);
        wake_check(HC);
        rd(ADDR_RST_CAUSE, {6'h00, CAUSE_PIN});
        wr(ADDR_WAKE_PINS, 8'h02);
        wr(ADDR_MODE_REQ, {6'h00, REQ_SHUTDOWN});
        cyc(3);
        chk({6'h00, powerCtl.alwaysOnPwr, powerCtl.ioLatch}, 8'h01);
        pins_u.toggle_pin(1);
        cyc(1);
        wake_check(HC);
        rd(ADDR_RST_CAUSE, {6'h00, CAUSE_WAKE});
        conclude();
    end
endmodule
bind power_mode_controller power_mode_properties chk_u (.clk(clk), .rst_n(rst_n),
    .resetPin_n(resetPin_n), .rechargePeriod(rechargePeriod), .slowClk(slowClk),
    .powerCtl(powerCtl), .clockCtl(clockCtl), .ramRetain(ramRetain),
    .brownoutEn(brownoutEn), .clkOutPin(clkOutPin));
`default_nettype wire
